// [bench/npr_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module npr_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] dout_in,
  output logic      [3:0] addr_out,
  output logic      [7:0] data_out,
  output logic            rd_out,
  output logic            wr_out
);
  // ------------------------------------------------------------
  // host cycles: setup 2, strobe 3 or 4, gap 3 or 4
  // ------------------------------------------------------------
  initial begin
    addr_out = 4'h0;
    data_out = 8'h00;
    rd_out   = 1'b0;
    wr_out   = 1'b0;
  end

  // page bits rewritten before every row page 3 only at offset 0
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    data_out = d;
    repeat (2) @(posedge clk_in);
    #1;
    wr_out = 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    wr_out   = 1'b0;
    data_out = ~d;
    repeat (3) @(posedge clk_in);
  endtask

  // page 2 used for read-back and for local pointer, next pointer and counter writes
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    data_out = ~data_out;
    repeat (2) @(posedge clk_in);
    #1;
    rd_out = 1'b1;
    repeat (4) @(posedge clk_in);
    #1;
    d      = dout_in;
    rd_out = 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// [bench/npr_paged_regs_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module npr_paged_regs_chk
  import npr_pkg::*;
(
  input wire logic                    clk_in,
  input wire logic                    rst_in,
  input wire logic [3:0]              reg_addr_in,
  input wire logic [7:0]              bus_data_in,
  input wire logic                    rd_strobe_in,
  input wire logic                    wr_strobe_in,
  input wire logic [7:0]              bus_data_out,
  input wire logic                    bus_data_oe_out,
  input wire npr_pkg::npr_core_stat_s core_stat_in,
  input wire npr_pkg::npr_core_cfg_s  core_cfg_out
);
  // ------------------------------------------------------------
  // host bus timing and register effects
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_oe_rise: assert property ($rose(rd_strobe_in) |-> ##3 bus_data_oe_out)
    else $error("drive enable late after read strobe");
  a_oe_fall: assert property ($fell(rd_strobe_in) |-> ##3 !bus_data_oe_out)
    else $error("drive enable held after read strobe");
  a_oe_cause: assert property (bus_data_oe_out |-> $past(rd_strobe_in, 3))
    else $error("drive enable without read");
  a_dout_hold: assert property ($changed(bus_data_out) |-> $rose(bus_data_oe_out))
    else $error("read data changed outside a read");
  a_rst_cmd: assert property ($fell(rst_in) |-> core_cfg_out.command_reg == CMD_RST)
    else $error("command register reset value wrong");
  a_cmd_write: assert property ($rose(wr_strobe_in) && reg_addr_in == OFS_CMD |->
    ##3 core_cfg_out.command_reg[7:6] == $past(bus_data_in[7:6], 3))
    else $error("page bits not loaded by command write");
  a_ldma_value: assert property (core_cfg_out.local_dma_load |-> $past(wr_strobe_in, 3)
    && $past(core_cfg_out.command_reg[7:6], 3) == PAGE_2
    && core_cfg_out.local_dma_value == ($past(reg_addr_in, 3) == OFS_01 ?
       {core_stat_in.local_dma_ptr[15:8], $past(bus_data_in, 3)} :
       {$past(bus_data_in, 3), core_stat_in.local_dma_ptr[7:0]}))
    else $error("local pointer load wrong");
  a_rsvd_stable: assert property ($rose(wr_strobe_in) && reg_addr_in[3:2] == 2'h3
    && core_cfg_out.command_reg[7:6] == PAGE_2 |=> $stable(core_cfg_out.rx_config) [*5])
    else $error("reserved write changed state");
  a_irq_sets: assert property (core_stat_in.irq_event != 8'h00 |=>
    (core_cfg_out.interrupt_status & $past(core_stat_in.irq_event))
    == $past(core_stat_in.irq_event))
    else $error("event did not set status");

  a_txreq_clear: assert property (core_stat_in.tx_done && !$past(wr_strobe_in, 2)
    |=> !core_cfg_out.command_reg[2])
    else $error("transmit request not cleared by core");

  c_read:  cover property ($rose(bus_data_oe_out));
  c_txclr: cover property ($fell(core_cfg_out.command_reg[2]));
  c_ldma:  cover property (core_cfg_out.local_dma_load);
  c_irq:   cover property ($rose(core_cfg_out.interrupt_status[0]));
endmodule

bind npr_paged_regs npr_paged_regs_chk u_chk (.clk_in(clk_in), .rst_in(rst_in),
  .reg_addr_in(reg_addr_in), .bus_data_in(bus_data_in), .rd_strobe_in(rd_strobe_in),
  .wr_strobe_in(wr_strobe_in), .bus_data_out(bus_data_out),
  .bus_data_oe_out(bus_data_oe_out), .core_stat_in(core_stat_in),
  .core_cfg_out(core_cfg_out));
`default_nettype wire

// [bench/test_nic_paged_register_decode.sv]
`timescale 1ns/10ps
`default_nettype none
module test_nic_paged_register_decode;
  import npr_pkg::*;
  typedef struct packed {
    logic [3:0] pg;
    logic [3:0] of;
    logic [7:0] wd;
    logic [7:0] rd;
  } npr_row_s;

  logic            clk_in = 1'b0;
  logic            rst_in = 1'b1;
  logic [3:0]      addr;
  logic [7:0]      wdat;
  logic [7:0]      dout;
  logic            rd;
  logic            wr;
  logic            oe;
  npr_core_stat_s  stat;
  npr_core_cfg_s   cfg;
  int              fails = 0;
  int              checks = 0;
  logic [7:0]      v;
  npr_row_s        r;
  logic [23:0]     rows [41] = '{
    24'h01a188, 24'h02a299, 24'h03a3a3, 24'h04a411, 24'h05a522, 24'h06a633, 24'h08a8aa,
    24'h09a9bb, 24'h0a5a00, 24'h0b5b00, 24'h0cc144, 24'h0dd155, 24'h0ee166, 24'h0ff177,
    24'h116161, 24'h126262, 24'h136363, 24'h146464, 24'h156565, 24'h166666, 24'h176767,
    24'h186868, 24'h196969, 24'h1a6a6a, 24'h1b6b6b, 24'h1c6c6c, 24'h1d6d6d, 24'h1e6e6e,
    24'h1f6f6f, 24'h2112a1, 24'h2213a2, 24'h233131, 24'h2444a4, 24'h253535, 24'h263636,
    24'h273737, 24'h284800, 24'h2c4cc1, 24'h2d4dd1, 24'h2e4ee1, 24'h2f4ff1};

  always #2.5 clk_in = ~clk_in;

  npr_host_model host (.clk_in(clk_in), .dout_in(dout), .addr_out(addr), .data_out(wdat),
    .rd_out(rd), .wr_out(wr));

  npr_paged_regs DUT (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr),
    .bus_data_in(wdat), .rd_strobe_in(rd), .wr_strobe_in(wr), .bus_data_out(dout),
    .bus_data_oe_out(oe), .core_stat_in(stat), .core_cfg_out(cfg));

  // ------------------------------------------------------------
  // compare and verdict
  // ------------------------------------------------------------
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic reset_dut;
    rst_in = 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    chk8("cmd after reset", CMD_RST, cfg.command_reg);
    chk8("oe after reset", 8'h00, {7'h0, oe});
    chk8("hash after reset", REG_RST, cfg.group_hash[7]);
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    fails++;
    print_verdict();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    stat = '{tx_status: 8'h11, collision_tally: 8'h22, tx_rx_queue_port: 8'h33,
      rx_status: 8'h44, align_err_tally: 8'h55, crc_err_tally: 8'h66,
      missed_pkt_tally: 8'h77, local_dma_ptr: 16'h9988, remote_dma_ptr: 16'hbbaa,
      irq_event: 8'h00, tx_done: 1'b0};
    reset_dut();
    foreach (rows[i]) begin
      r = rows[i];
      host.wr_reg(OFS_CMD, {r.pg[1:0], 6'h01});
      host.wr_reg(r.of, r.wd);
      host.rd_reg(r.of, v);
      chk8("row read", r.rd, v);
    end
    host.rd_reg(OFS_CMD, v);
    chk8("cmd read page 2", {PAGE_2, 6'h01}, v);
    chk16("tx length", 16'ha6a5, cfg.tx_len);
    chk16("remote base", 16'ha9a8, cfg.remote_base);
    chk16("remote length", 16'h5b5a, cfg.remote_len);
    chk16("addr counter", 16'h3637, cfg.addr_counter);
    chk8("fill page", 8'h67, cfg.ring_fill_page);
    chk8("station 0", 8'h61, cfg.station_addr[0]);
    chk8("hash 7", 8'h6f, cfg.group_hash[7]);
    host.wr_reg(OFS_CMD, {PAGE_3, 6'h01});
    host.rd_reg(OFS_05, v);
    chk8("page 3 read", RSVD_READ, v);
    host.rd_reg(OFS_CMD, v);
    chk8("cmd read page 3", {PAGE_3, 6'h01}, v);
    host.wr_reg(OFS_CMD, {PAGE_0, 6'h01});
    @(posedge clk_in);
    #1;
    stat.irq_event = 8'h05;
    @(posedge clk_in);
    #1;
    stat.irq_event = 8'h00;
    host.rd_reg(OFS_07, v);
    chk8("status set", 8'h05, v);
    host.wr_reg(OFS_07, 8'h01);
    host.rd_reg(OFS_07, v);
    chk8("status cleared", 8'h04, v);
    chk8("status out", 8'h04, cfg.interrupt_status);
    host.wr_reg(OFS_CMD, {PAGE_0, 6'h05});
    host.wr_reg(OFS_CMD, {PAGE_0, 6'h01});
    @(posedge clk_in);
    #1;
    chk8("txreq kept", {PAGE_0, 6'h05}, cfg.command_reg);
    stat.tx_done = 1'b1;
    @(posedge clk_in);
    #1;
    stat.tx_done = 1'b0;
    @(posedge clk_in);
    #1;
    chk8("txreq cleared", {PAGE_0, 6'h01}, cfg.command_reg);
    reset_dut();
    print_verdict();
  end
endmodule
`default_nettype wire

// [logic/npr_paged_regs.sv]
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// (R1) all registers are eight bits and each, except command at 00h, sits in a page chosen by page bits
// (R2) page comes from command register page bits; command is at 00h on every page
// (R3) four-bit host address selects one of sixteen locations in the active page
// (R4) page 0 reads show core status; writes at same offsets load configuration
// (R5) page 1 holds station address, ring fill page and multicast hash, all read/write
// (R6) page 2 reads back config, loads local pointer, reads/writes next pointers, counter
// (R7) host never writes while page 3 is selected; command at 00h is still written there, other page 3 writes are ignored
// (R8) page bits, abort bit and halt bit may change at any time
// (R9) reserved writes change nothing; reserved reads return a value without side effects
module npr_paged_regs (
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  input  wire logic [3:0]             reg_addr_in,
  input  wire logic [7:0]             bus_data_in,
  input  wire logic                   rd_strobe_in,
  input  wire logic                   wr_strobe_in,
  output logic      [7:0]             bus_data_out,
  output logic                        bus_data_oe_out,
  input  wire npr_pkg::npr_core_stat_s core_stat_in,
  output npr_pkg::npr_core_cfg_s      core_cfg_out
);
  import npr_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0]     addr_s1;
    logic [ADDR_W-1:0]     addr_s2;
    logic [REG_W-1:0]      data_s1;
    logic [REG_W-1:0]      data_s2;
    logic                  rd_s1;
    logic                  rd_s2;
    logic                  rd_s3;
    logic                  wr_s1;
    logic                  wr_s2;
    logic                  wr_s3;
    logic [REG_W-1:0]      rdata;
    logic                  oe;
    npr_core_cfg_s         cfg;
  } npr_state_s;

  npr_state_s state_r;
  npr_state_s state_nxt;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [2*REG_W-1:0] put_byte(
    input logic [2*REG_W-1:0] word,
    input logic               hi,
    input logic [REG_W-1:0]   val
  );
    logic [2*REG_W-1:0] res;
    res = word;
    if (hi) begin
      res[2*REG_W-1:REG_W] = val;
    end else begin
      res[REG_W-1:0] = val;
    end
    return res;
  endfunction

  function automatic logic [REG_W-1:0] get_byte(
    input logic [2*REG_W-1:0] word,
    input logic               hi
  );
    return hi ? word[2*REG_W-1:REG_W] : word[REG_W-1:0];
  endfunction

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  logic [PAGE_W-1:0] page;
  logic [ADDR_W-1:0] ofs;
  logic              wr_evt;
  logic              rd_evt;
  logic [REG_W-1:0]  wdat;
  logic [REG_W-1:0]  rmux;
  logic [ADDR_W-1:0] sta_idx;
  logic [ADDR_W-1:0] hsh_idx;

  assign page    = state_r.cfg.command_reg[CMD_PS_HI:CMD_PS_LO]; // [R2]
  assign ofs     = state_r.addr_s2; // [R3]
  assign wdat    = state_r.data_s2;
  assign wr_evt  = state_r.wr_s2 & ~state_r.wr_s3;
  assign rd_evt  = state_r.rd_s2 & ~state_r.rd_s3;
  assign sta_idx = ofs - OFS_STA0;
  assign hsh_idx = ofs - OFS_HSH0;

  // ------------------------------------------------------------
  // read multiplexer
  // ------------------------------------------------------------
  always_comb begin
    rmux = RSVD_READ; // [R9]
    if (ofs == OFS_CMD) begin
      rmux = state_r.cfg.command_reg; // [R2]
    end else begin
      case (page)
        PAGE_0: begin
          case (ofs) // [R4]
            OFS_01: rmux = get_byte(core_stat_in.local_dma_ptr, 1'b0);
            OFS_02: rmux = get_byte(core_stat_in.local_dma_ptr, 1'b1);
            OFS_03: rmux = state_r.cfg.ring_boundary_ptr;
            OFS_04: rmux = core_stat_in.tx_status;
            OFS_05: rmux = core_stat_in.collision_tally;
            OFS_06: rmux = core_stat_in.tx_rx_queue_port;
            OFS_07: rmux = state_r.cfg.interrupt_status;
            OFS_08: rmux = get_byte(core_stat_in.remote_dma_ptr, 1'b0);
            OFS_09: rmux = get_byte(core_stat_in.remote_dma_ptr, 1'b1);
            OFS_0C: rmux = core_stat_in.rx_status;
            OFS_0D: rmux = core_stat_in.align_err_tally;
            OFS_0E: rmux = core_stat_in.crc_err_tally;
            OFS_0F: rmux = core_stat_in.missed_pkt_tally;
            default: rmux = RSVD_READ; // [R9]
          endcase
        end
        PAGE_1: begin
          if (ofs < OFS_07) begin
            rmux = state_r.cfg.station_addr[sta_idx[2:0]]; // [R5]
          end else if (ofs == OFS_07) begin
            rmux = state_r.cfg.ring_fill_page; // [R5]
          end else begin
            rmux = state_r.cfg.group_hash[hsh_idx[2:0]]; // [R5]
          end
        end
        PAGE_2: begin
          case (ofs) // [R6]
            OFS_01: rmux = state_r.cfg.ring_first_page;
            OFS_02: rmux = state_r.cfg.ring_end_page;
            OFS_03: rmux = state_r.cfg.remote_next_pkt_ptr;
            OFS_04: rmux = state_r.cfg.tx_page_base;
            OFS_05: rmux = state_r.cfg.local_next_pkt_ptr;
            OFS_06: rmux = get_byte(state_r.cfg.addr_counter, 1'b1);
            OFS_07: rmux = get_byte(state_r.cfg.addr_counter, 1'b0);
            OFS_0C: rmux = state_r.cfg.rx_config;
            OFS_0D: rmux = state_r.cfg.tx_config;
            OFS_0E: rmux = state_r.cfg.data_config;
            OFS_0F: rmux = state_r.cfg.irq_mask;
            default: rmux = RSVD_READ; // [R9]
          endcase
        end
        default: rmux = RSVD_READ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    // pin synchronisers
    state_nxt.addr_s1 = reg_addr_in;
    state_nxt.addr_s2 = state_r.addr_s1;
    state_nxt.data_s1 = bus_data_in;
    state_nxt.data_s2 = state_r.data_s1;
    state_nxt.rd_s1   = rd_strobe_in;
    state_nxt.rd_s2   = state_r.rd_s1;
    state_nxt.rd_s3   = state_r.rd_s2;
    state_nxt.wr_s1   = wr_strobe_in;
    state_nxt.wr_s2   = state_r.wr_s1;
    state_nxt.wr_s3   = state_r.wr_s2;

    // read data capture, no side effects
    state_nxt.oe = state_r.rd_s2;
    if (rd_evt) begin
      state_nxt.rdata = rmux; // [R9]
    end

    state_nxt.cfg.local_dma_load = 1'b0;

    // transmit request cleared by core when done; a command write in the same cycle keeps it set
    if (core_stat_in.tx_done) begin
      state_nxt.cfg.command_reg[CMD_TXREQ] = 1'b0;
    end

    if (wr_evt) begin
      if (ofs == OFS_CMD) begin
        // page, abort, halt taken regardless of activity
        state_nxt.cfg.command_reg = wdat; // [R2] [R8]
        state_nxt.cfg.command_reg[CMD_TXREQ] =
          state_r.cfg.command_reg[CMD_TXREQ] | wdat[CMD_TXREQ];
      end else begin
        case (page)
          PAGE_0: begin
            case (ofs) // [R4]
              OFS_01: state_nxt.cfg.ring_first_page = wdat;
              OFS_02: state_nxt.cfg.ring_end_page = wdat;
              OFS_03: state_nxt.cfg.ring_boundary_ptr = wdat;
              OFS_04: state_nxt.cfg.tx_page_base = wdat;
              OFS_05: state_nxt.cfg.tx_len = put_byte(state_r.cfg.tx_len, 1'b0, wdat);
              OFS_06: state_nxt.cfg.tx_len = put_byte(state_r.cfg.tx_len, 1'b1, wdat);
              OFS_08: begin
                state_nxt.cfg.remote_base =
                  put_byte(state_r.cfg.remote_base, 1'b0, wdat);
              end
              OFS_09: begin
                state_nxt.cfg.remote_base =
                  put_byte(state_r.cfg.remote_base, 1'b1, wdat);
              end
              OFS_0A: begin
                state_nxt.cfg.remote_len =
                  put_byte(state_r.cfg.remote_len, 1'b0, wdat);
              end
              OFS_0B: begin
                state_nxt.cfg.remote_len =
                  put_byte(state_r.cfg.remote_len, 1'b1, wdat);
              end
              OFS_0C: state_nxt.cfg.rx_config = wdat;
              OFS_0D: state_nxt.cfg.tx_config = wdat;
              OFS_0E: state_nxt.cfg.data_config = wdat;
              OFS_0F: state_nxt.cfg.irq_mask = wdat;
              default: state_nxt.cfg = state_nxt.cfg;
            endcase
          end
          PAGE_1: begin
            if (ofs < OFS_07) begin
              state_nxt.cfg.station_addr[sta_idx[2:0]] = wdat; // [R5]
            end else if (ofs == OFS_07) begin
              state_nxt.cfg.ring_fill_page = wdat; // [R5]
            end else begin
              state_nxt.cfg.group_hash[hsh_idx[2:0]] = wdat; // [R5]
            end
          end
          PAGE_2: begin
            case (ofs) // [R6]
              OFS_01: begin
                state_nxt.cfg.local_dma_value =
                  put_byte(core_stat_in.local_dma_ptr, 1'b0, wdat);
                state_nxt.cfg.local_dma_load = 1'b1;
              end
              OFS_02: begin
                state_nxt.cfg.local_dma_value =
                  put_byte(core_stat_in.local_dma_ptr, 1'b1, wdat);
                state_nxt.cfg.local_dma_load = 1'b1;
              end
              OFS_03: state_nxt.cfg.remote_next_pkt_ptr = wdat;
              OFS_05: state_nxt.cfg.local_next_pkt_ptr = wdat;
              OFS_06: begin
                state_nxt.cfg.addr_counter =
                  put_byte(state_r.cfg.addr_counter, 1'b1, wdat);
              end
              OFS_07: begin
                state_nxt.cfg.addr_counter =
                  put_byte(state_r.cfg.addr_counter, 1'b0, wdat);
              end
              default: state_nxt.cfg = state_nxt.cfg; // [R9]
            endcase
          end
          default: state_nxt.cfg = state_nxt.cfg; // [R7]
        endcase
      end
    end

    // interrupt status: write one clears, core event wins
    if (wr_evt && ofs == OFS_07 && page == PAGE_0) begin
      state_nxt.cfg.interrupt_status =
        (state_r.cfg.interrupt_status & ~wdat) | core_stat_in.irq_event; // [R4]
    end else begin
      state_nxt.cfg.interrupt_status =
        state_r.cfg.interrupt_status | core_stat_in.irq_event;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r                 <= '0;
      state_r.cfg.command_reg <= CMD_RST; // [R1]
    end else begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign bus_data_out    = state_r.rdata;
  assign bus_data_oe_out = state_r.oe;
  assign core_cfg_out    = state_r.cfg;

endmodule

`default_nettype wire

// [logic/npr_pkg.sv]
package npr_pkg;

  // ------------------------------------------------------------
  // widths and pages
  // ------------------------------------------------------------
  localparam int unsigned REG_W  = 8;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned PAGE_W = 2;

  localparam logic [PAGE_W-1:0] PAGE_0 = 2'h0;
  localparam logic [PAGE_W-1:0] PAGE_1 = 2'h1;
  localparam logic [PAGE_W-1:0] PAGE_2 = 2'h2;
  localparam logic [PAGE_W-1:0] PAGE_3 = 2'h3;

  // ------------------------------------------------------------
  // offsets within a page
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CMD  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_01   = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_02   = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_03   = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_04   = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_05   = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_06   = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_07   = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_08   = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_09   = 4'h9;
  localparam logic [ADDR_W-1:0] OFS_0A   = 4'ha;
  localparam logic [ADDR_W-1:0] OFS_0B   = 4'hb;
  localparam logic [ADDR_W-1:0] OFS_0C   = 4'hc;
  localparam logic [ADDR_W-1:0] OFS_0D   = 4'hd;
  localparam logic [ADDR_W-1:0] OFS_0E   = 4'he;
  localparam logic [ADDR_W-1:0] OFS_0F   = 4'hf;
  localparam logic [ADDR_W-1:0] OFS_STA0 = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_HSH0 = 4'h8;

  // ------------------------------------------------------------
  // command register fields and reset values
  // ------------------------------------------------------------
  localparam int unsigned CMD_HALT  = 0;
  localparam int unsigned CMD_START = 1;
  localparam int unsigned CMD_TXREQ = 2;
  localparam int unsigned CMD_ABORT = 5;
  localparam int unsigned CMD_PS_LO = 6;
  localparam int unsigned CMD_PS_HI = 7;

  localparam logic [REG_W-1:0] CMD_RST   = 8'h01;
  localparam logic [REG_W-1:0] REG_RST   = 8'h00;
  localparam logic [REG_W-1:0] RSVD_READ = 8'h00;

  // ------------------------------------------------------------
  // carriers to and from the core
  // ------------------------------------------------------------
  typedef struct packed {
    logic [REG_W-1:0]   tx_status;
    logic [REG_W-1:0]   collision_tally;
    logic [REG_W-1:0]   tx_rx_queue_port;
    logic [REG_W-1:0]   rx_status;
    logic [REG_W-1:0]   align_err_tally;
    logic [REG_W-1:0]   crc_err_tally;
    logic [REG_W-1:0]   missed_pkt_tally;
    logic [2*REG_W-1:0] local_dma_ptr;
    logic [2*REG_W-1:0] remote_dma_ptr;
    logic [REG_W-1:0]   irq_event;
    logic               tx_done;
  } npr_core_stat_s;

  typedef struct packed {
    logic [REG_W-1:0]      command_reg;
    logic [REG_W-1:0]      ring_first_page;
    logic [REG_W-1:0]      ring_end_page;
    logic [REG_W-1:0]      ring_boundary_ptr;
    logic [REG_W-1:0]      tx_page_base;
    logic [2*REG_W-1:0]    tx_len;
    logic [2*REG_W-1:0]    remote_base;
    logic [2*REG_W-1:0]    remote_len;
    logic [REG_W-1:0]      rx_config;
    logic [REG_W-1:0]      tx_config;
    logic [REG_W-1:0]      data_config;
    logic [REG_W-1:0]      irq_mask;
    logic [REG_W-1:0]      interrupt_status;
    logic [5:0][REG_W-1:0] station_addr;
    logic [REG_W-1:0]      ring_fill_page;
    logic [7:0][REG_W-1:0] group_hash;
    logic [REG_W-1:0]      remote_next_pkt_ptr;
    logic [REG_W-1:0]      local_next_pkt_ptr;
    logic [2*REG_W-1:0]    addr_counter;
    logic                  local_dma_load;
    logic [2*REG_W-1:0]    local_dma_value;
  } npr_core_cfg_s;

endpackage
